// ---- ldfss_regs.svh ----
`ifndef LDFSS_REGS_SVH
`define LDFSS_REGS_SVH

// Time base
`define LDFSS_CLK_NS        40
`define LDFSS_TICK_NS       10000
`define LDFSS_NS_PER_MS     1000000
`define LDFSS_NS_PER_US     1000

// Supervisory times
`define LDFSS_SHORT_MS      90
`define LDFSS_RECOV_MS      4000
`define LDFSS_STEP_RST_MS   3000
`define LDFSS_BLANK_US      250

// Reference levels in percent of the 250 mV full reference
`define LDFSS_REF_FULL_MV   250
`define LDFSS_PCT_100       7'h64
`define LDFSS_PCT_70        7'h46
`define LDFSS_PCT_25        7'h19
`define LDFSS_PCT_5         7'h05
`define LDFSS_PCT_50        7'h32
`define LDFSS_PCT_STEP      7'h01

// Step dimming
`define LDFSS_STEP_FULL     2'h0
`define LDFSS_STEP_70       2'h1
`define LDFSS_STEP_25       2'h2
`define LDFSS_STEP_5        2'h3

// Over-current run length
`define LDFSS_OCP_RUN       3'h4
`define LDFSS_OCP_ZERO      3'h0
`define LDFSS_OCP_ONE       3'h1

// Valley numbers, low line / high line
`define LDFSS_VAL_LL_100    3'h1
`define LDFSS_VAL_HL_100    3'h2
`define LDFSS_VAL_LL_70     3'h2
`define LDFSS_VAL_HL_70     3'h3
`define LDFSS_VAL_LL_25     3'h5
`define LDFSS_VAL_HL_25     3'h6

`endif

// ---- ldfss_pkg.sv ----
`default_nettype none
package ldfss_pkg;

  typedef enum logic [1:0] {
    LDFSS_OFF   = 2'b00,
    LDFSS_RUN   = 2'b01,
    LDFSS_RECOV = 2'b10,
    LDFSS_LATCH = 2'b11
  } ldfss_state_t;

  // Comparator levels from the analog front end
  typedef struct packed {
    logic supply_ok;        // Supply above start level, until below stop level
    logic supply_ovp;       // Supply over-voltage
    logic line_low;         // Line sense below brownout_low_level
    logic line_high;        // High-line range detected
    logic fold_start;       // Shutdown pin below foldback start level
    logic fold_floor;       // Shutdown pin below foldback floor level
    logic sd_otp;           // Shutdown pin below over-temperature-off level
    logic sd_ovp;           // Shutdown pin above over-voltage level
    logic cs_limit;         // Current sense above peak_current_limit
    logic cs_150;           // Current sense above 150 % of the limit
    logic cs_setpoint;      // Current sense above control/4 setpoint
    logic valley_short_ok;  // Valley sense above short_detect_level
    logic valley_clock;     // Turn-on clock from valley logic
    logic ota_sinking;      // transconductance_amp sinks current
  } ldfss_cmp_t;

endpackage
`default_nettype wire

// ---- ldfss_tick.sv ----
`timescale 1ns/1ns
`default_nettype none
module ldfss_tick #(
  parameter int CYCLES = 250
) (
  input  wire logic clk,
  input  wire logic rst,
  output var  logic tick
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;

  always_comb begin
    if (cnt_r == 16'(CYCLES - 1)) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt  = cnt_r + 16'h0001;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule
`default_nettype wire

// ---- ldfss_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module ldfss_timer #(
  parameter int W     = 20,
  parameter int LIMIT = 9000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clr,
  input  wire logic run,
  input  wire logic tick,
  output var  logic done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         done_r;
  logic         done_nxt;

  // Counts ticks while run is high, saturates at LIMIT; clear wins
  always_comb begin
    cnt_nxt = cnt_r;
    if (clr) begin
      cnt_nxt = '0;
    end else if (run && tick && !done_r) begin
      cnt_nxt = cnt_r + W'(1);
    end
    done_nxt = !clr && (cnt_nxt >= W'(LIMIT));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
endmodule
`default_nettype wire

// ---- ldfss_top.sv ----
// Summary of operation
// - Brownout events step the current reference down through three reduced levels, the fourth back to full.
// - Line sense low beyond three seconds returns step dimming to full.
// - Shutdown-pin heating ramps the reference down, never below half.
// - Further heating past the second threshold holds the reference at half.
// - Pulling the shutdown pin under over-temperature level stops the device.
// - Shutdown pin above over-voltage level stops the controller.
// - Shutdown-pin faults latch or recover after four seconds, by variant.
// - Current above the peak limit ends gate drive for that cycle.
// - Four consecutive cycles above 150 percent limit cause a variant fault.
// - Valley sense low for 90 ms declares output short, variant fault.
// - Supply over-voltage shuts down, then waits four seconds.
// - On-time ends when current sense passes the control/4 setpoint.
// - Reference is full 250 mV, lower under dimming or foldback.
// - Major faults ground the loop filter; supply lockout does not.
// - Start-up charge source stays on until the amplifier sinks current.
// - Reference held full after start-up until valley sense reaches 1 V.
// - Short timer and full reference persist across failed supply cycles.
// - After supply loss, retry at start level keeping loop-filter level.
// - Shorted load hiccups on supply until the short timer trips.
// - Selected valley stays locked until line range or setpoint changes.
// - Brownout counter selects four levels and wraps to full after four.
// - Step levels are 100, 70, 25 and 5 percent of nominal.
// - Over-temperature detection is blanked 250 us after supply start.
`include "ldfss_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module ldfss_top #(
  parameter int TICK_CYCLES = (`LDFSS_TICK_NS + `LDFSS_CLK_NS - 1) / `LDFSS_CLK_NS,
  parameter int SHORT_TICKS = `LDFSS_SHORT_MS * (`LDFSS_NS_PER_MS / `LDFSS_TICK_NS),
  parameter int RECOV_TICKS = `LDFSS_RECOV_MS * (`LDFSS_NS_PER_MS / `LDFSS_TICK_NS),
  parameter int STEP_TICKS  = `LDFSS_STEP_RST_MS * (`LDFSS_NS_PER_MS / `LDFSS_TICK_NS),
  parameter int BLANK_TICKS = (`LDFSS_BLANK_US * `LDFSS_NS_PER_US + `LDFSS_TICK_NS - 1)
                              / `LDFSS_TICK_NS + 1,
  parameter int TW          = 20
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 variant_latch,
  input  wire ldfss_pkg::ldfss_cmp_t cmp,
  output var  logic                 gate_drive,
  output var  logic                 comp_ground,
  output var  logic                 startup_charge,
  output var  logic [6:0]           active_current_reference,
  output var  logic [1:0]           step_level,
  output var  logic [2:0]           valley_select,
  output var  logic                 recovery_wait,
  output var  logic                 fault_latched
);
  import ldfss_pkg::*;

  logic         tick;
  logic         blank_done;
  logic         short_done;
  logic         recov_done;
  logic         step_done;
  ldfss_state_t state_r, state_nxt;
  logic         recov_r, recov_nxt;
  logic         latch_r, latch_nxt;
  logic         gate_r, gate_nxt;
  logic         ground_r, ground_nxt;
  logic         charge_r, charge_nxt;
  logic         ota_seen_r, ota_seen_nxt;
  logic         hold_r, hold_nxt;
  logic [2:0]   ocp_r, ocp_nxt;
  logic         hit_r, hit_nxt;
  logic [1:0]   step_r, step_nxt;
  logic         line_low_r;
  logic [6:0]   fold_r, fold_nxt;
  logic [6:0]   ref_r, ref_nxt;
  logic [2:0]   valley_r, valley_nxt;
  logic         lock_line_r, lock_line_nxt;
  logic [1:0]   lock_step_r, lock_step_nxt;
  logic         run;
  logic         enter_run;
  logic         sd_fault;
  logic         ocp_fault;
  logic         variant_fault;
  logic         bo_event;
  logic [6:0]   step_pct;

  ldfss_tick #(.CYCLES (TICK_CYCLES)) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );
  assign run       = (state_r == LDFSS_RUN);
  assign enter_run = (state_r == LDFSS_OFF) && cmp.supply_ok;
  // Blanking of over-temperature at each supply start
  ldfss_timer #(.W (TW), .LIMIT (BLANK_TICKS)) u_blank (
    .clk  (clk),
    .rst  (rst),
    .clr  (enter_run),
    .run  (run),
    .tick (tick),
    .done (blank_done)
  );
  // Short timer: not cleared by supply loss, only by valley level or the recovery wait
  ldfss_timer #(.W (TW), .LIMIT (SHORT_TICKS)) u_short (
    .clk  (clk),
    .rst  (rst),
    .clr  (cmp.valley_short_ok || state_r == LDFSS_RECOV),
    .run  (run),
    .tick (tick),
    .done (short_done)
  );
  ldfss_timer #(.W (TW), .LIMIT (RECOV_TICKS)) u_recov (
    .clk  (clk),
    .rst  (rst),
    .clr  (state_r != LDFSS_RECOV),
    .run  (1'b1),
    .tick (tick),
    .done (recov_done)
  );
  ldfss_timer #(.W (TW), .LIMIT (STEP_TICKS)) u_step (
    .clk  (clk),
    .rst  (rst),
    .clr  (!cmp.line_low),
    .run  (1'b1),
    .tick (tick),
    .done (step_done)
  );
  // Fault classification
  assign sd_fault      = (cmp.sd_otp && blank_done) || cmp.sd_ovp;
  assign ocp_fault     = (ocp_r == `LDFSS_OCP_RUN);
  assign variant_fault = sd_fault || ocp_fault || short_done;
  // Operating state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LDFSS_OFF: begin
        if (cmp.supply_ok) begin
          state_nxt = LDFSS_RUN;
        end
      end
      LDFSS_RUN: begin
        if (variant_fault) begin
          state_nxt = variant_latch ? LDFSS_LATCH : LDFSS_RECOV;
        end else if (cmp.supply_ovp) begin
          state_nxt = LDFSS_RECOV;
        end else if (!cmp.supply_ok) begin
          state_nxt = LDFSS_OFF;
        end
      end
      LDFSS_RECOV: begin
        if (recov_done) begin
          state_nxt = LDFSS_OFF;
        end
      end
      LDFSS_LATCH: begin
        state_nxt = LDFSS_LATCH;
      end
      default: begin
        state_nxt = LDFSS_OFF;
      end
    endcase
    recov_nxt = (state_nxt == LDFSS_RECOV);
    latch_nxt = (state_nxt == LDFSS_LATCH);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= LDFSS_OFF;
      recov_r <= 1'b0;
      latch_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      recov_r <= recov_nxt;
      latch_r <= latch_nxt;
    end
  end
  // Gate drive and over-current run counting
  always_comb begin
    gate_nxt = gate_r;
    if (!run || variant_fault || cmp.supply_ovp || !cmp.supply_ok || cmp.line_low) begin
      gate_nxt = 1'b0;
    end else if (cmp.cs_limit || cmp.cs_setpoint) begin
      gate_nxt = 1'b0;
    end else if (cmp.valley_clock) begin
      gate_nxt = 1'b1;
    end
    hit_nxt = hit_r;
    ocp_nxt = ocp_r;
    if (!run) begin
      hit_nxt = 1'b0;
      ocp_nxt = `LDFSS_OCP_ZERO;
    end else if (gate_r && !gate_nxt) begin
      hit_nxt = 1'b0;
      if (hit_r || cmp.cs_150) begin
        ocp_nxt = ocp_r + `LDFSS_OCP_ONE;
      end else begin
        ocp_nxt = `LDFSS_OCP_ZERO;
      end
    end else if (gate_r && cmp.cs_150) begin
      hit_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_r <= 1'b0;
      hit_r  <= 1'b0;
      ocp_r  <= `LDFSS_OCP_ZERO;
    end else begin
      gate_r <= gate_nxt;
      hit_r  <= hit_nxt;
      ocp_r  <= ocp_nxt;
    end
  end

  // Loop filter grounding, start-up charge, full-reference hold
  always_comb begin
    ground_nxt   = ground_r;
    ota_seen_nxt = ota_seen_r;
    hold_nxt     = hold_r;
    if (state_nxt == LDFSS_RECOV || state_nxt == LDFSS_LATCH) begin
      ground_nxt   = 1'b1;
      ota_seen_nxt = 1'b0;
      hold_nxt     = 1'b1;
    end else if (state_nxt == LDFSS_RUN) begin
      ground_nxt = 1'b0;
      if (cmp.ota_sinking) begin
        ota_seen_nxt = 1'b1;
      end
      if (cmp.valley_short_ok) begin
        hold_nxt = 1'b0;
      end
    end
    charge_nxt = (state_nxt == LDFSS_RUN) && !ota_seen_nxt;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ground_r   <= 1'b1;
      ota_seen_r <= 1'b0;
      hold_r     <= 1'b1;
      charge_r   <= 1'b0;
    end else begin
      ground_r   <= ground_nxt;
      ota_seen_r <= ota_seen_nxt;
      hold_r     <= hold_nxt;
      charge_r   <= charge_nxt;
    end
  end

  // Step dimming counter
  assign bo_event = cmp.line_low && !line_low_r;

  always_comb begin
    step_nxt = step_r;
    if (step_done) begin
      step_nxt = `LDFSS_STEP_FULL;
    end else if (bo_event) begin
      step_nxt = step_r + 2'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_r     <= `LDFSS_STEP_FULL;
      line_low_r <= 1'b0;
    end else begin
      step_r     <= step_nxt;
      line_low_r <= cmp.line_low;
    end
  end

  // Reference selection with thermal foldback
  always_comb begin
    case (step_r)
      `LDFSS_STEP_70: step_pct = `LDFSS_PCT_70;
      `LDFSS_STEP_25: step_pct = `LDFSS_PCT_25;
      `LDFSS_STEP_5:  step_pct = `LDFSS_PCT_5;
      default:        step_pct = `LDFSS_PCT_100;
    endcase
    fold_nxt = fold_r;
    if (tick) begin
      if (cmp.fold_start && !cmp.fold_floor && fold_r > `LDFSS_PCT_50) begin
        fold_nxt = fold_r - `LDFSS_PCT_STEP;
      end else if (cmp.fold_floor) begin
        fold_nxt = `LDFSS_PCT_50;
      end else if (!cmp.fold_start && fold_r < `LDFSS_PCT_100) begin
        fold_nxt = fold_r + `LDFSS_PCT_STEP;
      end
    end
    if (hold_r) begin
      ref_nxt = `LDFSS_PCT_100;
    end else if (fold_r < step_pct) begin
      ref_nxt = fold_r;
    end else begin
      ref_nxt = step_pct;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fold_r <= `LDFSS_PCT_100;
      ref_r  <= `LDFSS_PCT_100;
    end else begin
      fold_r <= fold_nxt;
      ref_r  <= ref_nxt;
    end
  end

  // Valley lock: re-select only on line range or setpoint change
  always_comb begin
    valley_nxt    = valley_r;
    lock_line_nxt = lock_line_r;
    lock_step_nxt = lock_step_r;
    if (cmp.line_high != lock_line_r || step_r != lock_step_r) begin
      lock_line_nxt = cmp.line_high;
      lock_step_nxt = step_r;
      case (step_r)
        `LDFSS_STEP_FULL: valley_nxt = cmp.line_high ? `LDFSS_VAL_HL_100 : `LDFSS_VAL_LL_100;
        `LDFSS_STEP_70:   valley_nxt = cmp.line_high ? `LDFSS_VAL_HL_70 : `LDFSS_VAL_LL_70;
        default:          valley_nxt = cmp.line_high ? `LDFSS_VAL_HL_25 : `LDFSS_VAL_LL_25;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valley_r    <= `LDFSS_VAL_LL_100;
      lock_line_r <= 1'b0;
      lock_step_r <= `LDFSS_STEP_FULL;
    end else begin
      valley_r    <= valley_nxt;
      lock_line_r <= lock_line_nxt;
      lock_step_r <= lock_step_nxt;
    end
  end

  assign gate_drive               = gate_r;
  assign comp_ground              = ground_r;
  assign startup_charge           = charge_r;
  assign active_current_reference = ref_r;
  assign step_level               = step_r;
  assign valley_select            = valley_r;
  assign recovery_wait            = recov_r;
  assign fault_latched            = latch_r;
endmodule
`default_nettype wire

// ---- ldfss_top_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module ldfss_checker #(
  parameter int TICK_CYCLES = 4,
  parameter int RECOV_TICKS = 30
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire ldfss_pkg::ldfss_cmp_t cmp,
  input wire logic                  gate_drive,
  input wire logic                  comp_ground,
  input wire logic                  startup_charge,
  input wire logic [6:0]            active_current_reference,
  input wire logic [1:0]            step_level,
  input wire logic                  recovery_wait,
  input wire logic                  fault_latched
);
  import ldfss_pkg::*;
  logic [31:0] rcnt_r;
  logic [31:0] rcnt_nxt;
  // Length of the current recovery wait in clocks
  always_comb begin
    rcnt_nxt = recovery_wait ? rcnt_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rcnt_r <= 32'h0;
    end else begin
      rcnt_r <= rcnt_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_limit_gate_off: assert property (cmp.cs_limit |=> !gate_drive)
    else $error("gate stayed on above current limit");
  a_setpoint_gate_off: assert property (cmp.cs_setpoint |=> !gate_drive)
    else $error("gate stayed on above setpoint");
  a_fault_ground: assert property ((recovery_wait || fault_latched)
    |-> comp_ground && !gate_drive)
    else $error("fault without grounded loop filter");
  a_latch_holds: assert property (fault_latched |=> fault_latched)
    else $error("latched fault released");
  a_ref_range: assert property (active_current_reference <= 7'h64
    && active_current_reference >= 7'h05)
    else $error("reference out of range");
  a_step_wrap: assert property ((step_level != $past(step_level))
    |-> step_level == 2'($past(step_level) + 2'h1) || step_level == 2'h0)
    else $error("step level skipped");
  a_step_event: assert property ((step_level != $past(step_level) && step_level != 2'h0)
    |-> $past(cmp.line_low) || $past(cmp.line_low, 2))
    else $error("step without brownout event");
  a_recov_len: assert property ($fell(recovery_wait)
    |-> rcnt_r >= 32'((RECOV_TICKS - 1) * TICK_CYCLES))
    else $error("recovery wait too short");
  a_charge_off: assert property (startup_charge && cmp.ota_sinking |=> !startup_charge)
    else $error("charge source stayed on");
  c_recov: cover property ($rose(recovery_wait));
  c_latch: cover property ($rose(fault_latched));
  c_step3: cover property (step_level == 2'h3);
endmodule
`default_nettype wire

// ---- ldfss_stage_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ldfss_stage_model (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  gate_drive,
  input  wire ldfss_pkg::ldfss_cmp_t levels,
  input  wire logic [1:0]            cs_mode,
  input  wire logic                  vc_en,
  output var  ldfss_pkg::ldfss_cmp_t cmp
);
  import ldfss_pkg::*;
  logic [2:0] on_r;
  logic [2:0] on_nxt;
  logic [2:0] vc_r;
  logic [2:0] vc_nxt;
  logic       cs_hi;
  // Inductor current ramps for two clocks after turn-on
  always_comb begin
    on_nxt = gate_drive ? ((on_r == 3'h7) ? on_r : on_r + 3'h1) : 3'h0;
    vc_nxt = vc_r + 3'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      on_r <= 3'h0;
      vc_r <= 3'h0;
    end else begin
      on_r <= on_nxt;
      vc_r <= vc_nxt;
    end
  end
  assign cs_hi = gate_drive && (on_r >= 3'h2);
  always_comb begin
    cmp              = levels;
    cmp.valley_clock = vc_en && (vc_r == 3'h7) && !gate_drive;
    cmp.cs_setpoint  = cs_hi && (cs_mode == 2'h0);
    cmp.cs_limit     = cs_hi && (cs_mode != 2'h0);
    cmp.cs_150       = cs_hi && (cs_mode == 2'h2);
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ldfss_pkg::*;
  localparam logic [6:0] REF_T [4] = '{7'h64, 7'h46, 7'h19, 7'h05};
  localparam logic [2:0] VAL_T [4] = '{3'h1, 3'h2, 3'h5, 3'h5};
  logic       clk;
  logic       rst;
  logic       variant_latch;
  ldfss_cmp_t levels;
  ldfss_cmp_t cmp;
  logic [1:0] cs_mode;
  logic       vc_en;
  logic       gate_drive;
  logic       comp_ground;
  logic       startup_charge;
  logic [6:0] active_current_reference;
  logic [1:0] step_level;
  logic [2:0] valley_select;
  logic       recovery_wait;
  logic       fault_latched;
  int         errors;
  int         samples_checked;
  int         n;
  ldfss_top #(.TICK_CYCLES(4), .SHORT_TICKS(20), .RECOV_TICKS(30), .STEP_TICKS(25),
    .BLANK_TICKS(3)) dut_u (.clk(clk), .rst(rst), .variant_latch(variant_latch), .cmp(cmp),
    .gate_drive(gate_drive), .comp_ground(comp_ground), .startup_charge(startup_charge),
    .active_current_reference(active_current_reference), .step_level(step_level),
    .valley_select(valley_select), .recovery_wait(recovery_wait),
    .fault_latched(fault_latched));
  ldfss_stage_model stage_u (.clk(clk), .rst(rst), .gate_drive(gate_drive), .levels(levels),
    .cs_mode(cs_mode), .vc_en(vc_en), .cmp(cmp));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bo_pulse();
    levels.line_low = 1'b1;
    cyc(2);
    levels.line_low = 1'b0;
    cyc(3);
  endtask
  task automatic recover(input string name);
    for (n = 0; n < 200 && recovery_wait !== 1'b0; n++) cyc(1);
    chk(name, 8'h00, 8'(recovery_wait));
    cyc(2);
  endtask
  task automatic t_startup();
    chk("rst_ground", 8'h01, 8'(comp_ground));
    chk("rst_ref", 8'h64, 8'(active_current_reference));
    levels.supply_ok = 1'b1;
    cyc(2);
    chk("charge_on", 8'h01, 8'(startup_charge));
    chk("ground_off", 8'h00, 8'(comp_ground));
    vc_en = 1'b1;
    for (n = 0; n < 40 && gate_drive !== 1'b1; n++) cyc(1);
    chk("gate_on", 8'h01, 8'(gate_drive));
    cyc(4);
    chk("gate_end", 8'h00, 8'(gate_drive));
    bo_pulse();
    chk("step_one", 8'h01, 8'(step_level));
    chk("ref_held", 8'h64, 8'(active_current_reference));
    levels.ota_sinking = 1'b1;
    cyc(2);
    chk("charge_off", 8'h00, 8'(startup_charge));
    levels.valley_short_ok = 1'b1;
    cyc(3);
    chk("ref_free", 8'h46, 8'(active_current_reference));
  endtask
  task automatic t_steps();
    for (int i = 2; i <= 5; i++) begin
      bo_pulse();
      chk("step", 8'(i % 4), 8'(step_level));
      chk("step_ref", 8'(REF_T[i % 4]), 8'(active_current_reference));
      chk("valley", 8'(VAL_T[i % 4]), 8'(valley_select));
    end
    levels.line_low = 1'b1;
    cyc(40);
    chk("step_two", 8'h02, 8'(step_level));
    cyc(75);
    chk("step_reset", 8'h00, 8'(step_level));
    levels.line_low = 1'b0;
    levels.line_high = 1'b1;
    cyc(3);
    chk("valley_hl", 8'h02, 8'(valley_select));
  endtask
  task automatic t_fold_otp();
    levels.fold_start = 1'b1;
    cyc(40);
    chk("fold_ramp", 8'h01, 8'(active_current_reference < 7'h64
      && active_current_reference > 7'h32));
    levels.fold_floor = 1'b1;
    cyc(6);
    chk("fold_floor", 8'h32, 8'(active_current_reference));
    levels.sd_otp = 1'b1;
    cyc(2);
    chk("otp_stop", 8'h01, 8'(recovery_wait));
    chk("otp_ground", 8'h01, 8'(comp_ground));
    levels.sd_otp = 1'b0;
    levels.fold_start = 1'b0;
    levels.fold_floor = 1'b0;
    recover("otp_recov");
    levels.sd_otp = 1'b1;
    cyc(4);
    levels.sd_otp = 1'b0;
    cyc(2);
    chk("otp_blank", 8'h00, 8'(recovery_wait));
  endtask
  task automatic t_ovp();
    levels.sd_ovp = 1'b1;
    cyc(2);
    chk("sd_ovp", 8'h01, 8'(recovery_wait));
    levels.sd_ovp = 1'b0;
    recover("sd_ovp_recov");
    variant_latch = 1'b1;
    levels.supply_ovp = 1'b1;
    cyc(2);
    chk("vcc_ovp", 8'h01, 8'(recovery_wait));
    levels.supply_ovp = 1'b0;
    recover("vcc_ovp_recov");
    chk("vcc_no_latch", 8'h00, 8'(fault_latched));
    variant_latch = 1'b0;
  endtask
  task automatic t_overcurrent();
    logic g_prev;
    int   pulses;
    for (n = 0; n < 40 && gate_drive !== 1'b0; n++) cyc(1);
    cs_mode = 2'h2;
    g_prev = 1'b0;
    pulses = 0;
    for (n = 0; n < 200 && recovery_wait !== 1'b1; n++) begin
      if (gate_drive === 1'b1 && g_prev === 1'b0) pulses++;
      g_prev = gate_drive;
      cyc(1);
    end
    chk("ocp_runs", 8'h04, 8'(pulses));
    cs_mode = 2'h1;
    recover("ocp_recov");
    cyc(80);
    chk("limit_only", 8'h00, 8'(recovery_wait));
    cs_mode = 2'h0;
  endtask
  task automatic t_short();
    variant_latch = 1'b1;
    levels.valley_short_ok = 1'b0;
    cyc(40);
    levels.supply_ok = 1'b0;
    cyc(10);
    chk("uvlo_ground", 8'h00, 8'(comp_ground));
    levels.supply_ok = 1'b1;
    for (n = 0; n < 100 && fault_latched !== 1'b1; n++) cyc(1);
    chk("short_kept", 8'h01, 8'(n < 60));
    chk("short_latch", 8'h01, 8'(fault_latched));
    cyc(20);
    chk("latch_kept", 8'h01, 8'(fault_latched));
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    chk("latch_clear", 8'h00, 8'(fault_latched));
  endtask
  task automatic end_of_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    errors = 0;
    samples_checked = 0;
    rst = 1'b1;
    variant_latch = 1'b0;
    levels = '0;
    cs_mode = 2'h0;
    vc_en = 1'b0;
    cyc(3);
    rst = 1'b0;
    t_startup();
    t_steps();
    t_fold_otp();
    t_ovp();
    t_overcurrent();
    t_short();
    end_of_test();
  end
  initial begin
    #400000;
    errors++;
    end_of_test();
  end
endmodule
bind ldfss_top ldfss_checker #(.TICK_CYCLES(TICK_CYCLES), .RECOV_TICKS(RECOV_TICKS)) chk_u (
  .clk(clk), .rst(rst), .cmp(cmp), .gate_drive(gate_drive), .comp_ground(comp_ground),
  .startup_charge(startup_charge), .active_current_reference(active_current_reference),
  .step_level(step_level), .recovery_wait(recovery_wait), .fault_latched(fault_latched));
`default_nettype wire
